// *** common/smc_defines.svh ***
// Address map, field positions and reset values of the standby mode controller.
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

`define SMC_ADDR_W        12
`define SMC_PDCR_ADDR     12'hFBC
`define SMC_CTRL_ADDR     12'hFC0
`define SMC_WDT_ADDR      12'hFC4
`define SMC_STAT_ADDR     12'hFC8

`define SMC_PDCR_RST      8'h1F
`define SMC_PDCR_ONES     8'h1F
`define SMC_PDCR_SBY      7
`define SMC_PDCR_HIZ      6

`define SMC_CTRL_NMI_EDGE_SELECT     0

`define SMC_WDT_OVF       7
`define SMC_WDT_IT        6
`define SMC_WDT_TME       5
`define SMC_WDT_CKS_HI    2
`define SMC_WDT_CKS_LO    0
`define SMC_WDT_RW_MASK   8'h67
`define SMC_WDT_CLR_MASK  8'h1F
`define SMC_WATCHDOG_CONTROL_STATUS_RST      8'h00
`define SMC_CNT_RST       8'h00
`define SMC_CNT_MAX       8'hFF
`define SMC_CNT_ONE       8'h01
`define SMC_RSTS_RST      8'h00
`define SMC_PRESC_RST     12'h000
`define SMC_PRESC_ONE     12'h001

`define SMC_WORD_ZERO     32'h0000_0000
`define SMC_HTRANS_NONSEQ 1
`define SMC_HRESP_OKAY    1'b0

`endif

// *** common/smc_pkg.sv ***
// Types shared by the standby mode controller and its bench.
package smc_pkg;

  typedef enum logic [2:0] {
    SMC_ST_RUN    = 3'h1,
    SMC_ST_STBY   = 3'h2,
    SMC_ST_SETTLE = 3'h4
  } smc_state_e;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic wdt;
  } smc_clk_s;

  typedef struct packed {
    logic dmac;
    logic timer;
    logic serial;
  } smc_init_s;

endpackage : smc_pkg

// *** verilog/smc_standby.sv ***
// Standby mode controller: entry, hold and exit of deep standby, with AHB-Lite registers.
//
// Summary of operation
// - Standby bit plus sleep enters standby.
// - Standby stops CPU, system clock, peripherals.
// - CPU registers and RAM stay unchanged.
// - Ports held or floated by float bit.
// - Listed units and control register keep contents.
// - Entry resets DMA and timer unit registers.
// - Entry clears watchdog flags, keeps select, count.
// - Entry initialises all serial unit registers.
// - Only NMI or reset pin ends standby.
// - NMI edge restarts clock, watchdog only.
// - Watchdog overflow clocks chip, starts NMI.
// - Reset low, NMI high: power-on reset.
// - Reset low, NMI low: manual reset.
// - Unselected rising NMI edge never wakes.
// - Falling NMI edge wakes before manual reset.
// - Standby bit refused while watchdog runs.
// - Float bit one floats ports, zero holds.
`timescale 1ns/1ps
`include "smc_defines.svh"

module smc_standby (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              sleep_exec,
  input  wire logic              nmi_pin,
  input  wire logic              reset_pin,
  output logic                   cpu_halt,
  output smc_pkg::smc_clk_s      clk_en,
  output smc_pkg::smc_init_s     init,
  output logic                   wdt_flag_clr,
  output logic                   port_float,
  output logic                   port_hold,
  output logic                   nmi_exc_req,
  output logic                   por_req,
  output logic                   manual_reset_req,
  output logic                   standby_state
);
  import smc_pkg::*;

  smc_state_e              state_ff;
  smc_state_e              nxt_state;
  logic [7:0]              pdcr_ff;
  logic                    nmi_edge_select_ff;
  logic [7:0]              watchdog_control_status_ff;
  logic [7:0]              wdt_count_ff;
  logic [7:0]              rst_status_ff;
  logic [11:0]             presc_ff;
  logic                    nmi_d_ff;
  logic                    wr_pend_ff;
  logic [`SMC_ADDR_W-1:0]  wr_addr_ff;
  logic [31:0]             hrdata_ff;
  logic                    cpu_halt_ff;
  smc_clk_s                clk_en_ff;
  smc_init_s               init_ff;
  logic                    wdt_flag_clr_ff;
  logic                    port_float_ff;
  logic                    port_hold_ff;
  logic                    nmi_exc_req_ff;
  logic                    por_req_ff;
  logic                    manual_reset_req_ff;
  logic                    standby_state_ff;
  logic                    acc;
  logic                    enter_stby;
  logic                    wake_edge;
  logic                    wdt_tick;
  logic                    wdt_counting;
  logic                    wdt_ovf_evt;
  logic                    in_stby;
  logic [31:0]             rd_mux;

  // Prescaler tap: a count step every 2^(select+1) clock cycles.
  function automatic logic presc_tap(input logic [11:0] presc, input logic [2:0] sel);
    logic [11:0] mask;
    mask = (`SMC_PRESC_ONE << ({1'b0, sel} + 4'h1)) - `SMC_PRESC_ONE;
    return (presc & mask) == mask;
  endfunction : presc_tap

  function automatic logic addr_is(input logic [`SMC_ADDR_W-1:0] a,
                                   input logic [`SMC_ADDR_W-1:0] reg_addr);
    return a == reg_addr;
  endfunction : addr_is

  assign acc        = hsel && htrans[`SMC_HTRANS_NONSEQ] && hready;
  assign in_stby    = (state_ff == SMC_ST_STBY) || (state_ff == SMC_ST_SETTLE);
  assign enter_stby = (state_ff == SMC_ST_RUN) && sleep_exec && pdcr_ff[`SMC_PDCR_SBY];
  // only the selected NMI edge counts
  assign wake_edge  = nmi_edge_select_ff ? (nmi_pin && !nmi_d_ff) : (!nmi_pin && nmi_d_ff);
  assign wdt_tick   = presc_tap(presc_ff, watchdog_control_status_ff[`SMC_WDT_CKS_HI:`SMC_WDT_CKS_LO]);
  assign wdt_counting = (state_ff == SMC_ST_SETTLE) ||
                        ((state_ff == SMC_ST_RUN) && watchdog_control_status_ff[`SMC_WDT_TME] && !enter_stby);
  assign wdt_ovf_evt  = wdt_counting && wdt_tick && (wdt_count_ff == `SMC_CNT_MAX);

  // exits only by reset pin or NMI edge
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SMC_ST_RUN: begin
        if (enter_stby) begin
          nxt_state = SMC_ST_STBY;
        end
      end
      SMC_ST_STBY: begin
        if (!reset_pin) begin
          nxt_state = SMC_ST_RUN;
        end else if (wake_edge) begin
          nxt_state = SMC_ST_SETTLE;
        end
      end
      SMC_ST_SETTLE: begin
        if (!reset_pin || wdt_ovf_evt) begin
          nxt_state = SMC_ST_RUN;
        end
      end
      default: nxt_state = SMC_ST_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= SMC_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_d_ff <= 1'b1;
    end else begin
      nmi_d_ff <= nmi_pin;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_halt_ff      <= 1'b0;
      clk_en_ff        <= '{cpu: 1'b1, periph: 1'b1, wdt: 1'b1};
      standby_state_ff <= 1'b0;
    end else begin
      cpu_halt_ff      <= nxt_state != SMC_ST_RUN;
      clk_en_ff.cpu    <= nxt_state == SMC_ST_RUN;
      clk_en_ff.periph <= nxt_state == SMC_ST_RUN;
      clk_en_ff.wdt    <= nxt_state != SMC_ST_STBY;
      standby_state_ff <= nxt_state != SMC_ST_RUN;
    end
  end

  // port hold or float while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_float_ff <= 1'b0;
      port_hold_ff  <= 1'b0;
    end else begin
      // float bit chooses the port state
      port_float_ff <= (nxt_state != SMC_ST_RUN) && pdcr_ff[`SMC_PDCR_HIZ];
      port_hold_ff  <= (nxt_state != SMC_ST_RUN) && !pdcr_ff[`SMC_PDCR_HIZ];
    end
  end

  // entry pulse initialises DMA and timers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_ff         <= '0;
      wdt_flag_clr_ff <= 1'b0;
    end else begin
      init_ff.dmac    <= enter_stby;
      init_ff.timer   <= enter_stby;
      init_ff.serial  <= enter_stby;
      wdt_flag_clr_ff <= enter_stby;
    end
  end

  // reset pin exit, cause from NMI level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_req_ff          <= 1'b0;
      manual_reset_req_ff <= 1'b0;
      nmi_exc_req_ff      <= 1'b0;
    end else begin
      por_req_ff          <= in_stby && !reset_pin && nmi_pin;
      manual_reset_req_ff <= in_stby && !reset_pin && !nmi_pin;
      // overflow ends settling with NMI request
      nmi_exc_req_ff      <= (state_ff == SMC_ST_SETTLE) && reset_pin && wdt_ovf_evt;
    end
  end

  // Watchdog prescaler and counter; the count survives standby entry.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_ff     <= `SMC_PRESC_RST;
      wdt_count_ff <= `SMC_CNT_RST;
    end else begin
      presc_ff <= wdt_counting ? presc_ff + `SMC_PRESC_ONE : presc_ff;
      if (wr_pend_ff && addr_is(wr_addr_ff, `SMC_WDT_ADDR)) begin
        wdt_count_ff <= hwdata[15:8];
      end else if (wdt_counting && wdt_tick) begin
        wdt_count_ff <= wdt_count_ff + `SMC_CNT_ONE;
      end
    end
  end

  // Overflow set is applied last, so it wins over a clearing write in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_control_status_ff       <= `SMC_WATCHDOG_CONTROL_STATUS_RST;
      rst_status_ff <= `SMC_RSTS_RST;
    end else begin
      if (wr_pend_ff && addr_is(wr_addr_ff, `SMC_WDT_ADDR)) begin
        watchdog_control_status_ff <= (watchdog_control_status_ff & ~`SMC_WDT_RW_MASK) | (hwdata[7:0] & `SMC_WDT_RW_MASK);
        if (!hwdata[`SMC_WDT_OVF]) begin
          watchdog_control_status_ff[`SMC_WDT_OVF] <= 1'b0;
        end
        rst_status_ff <= hwdata[23:16];
      end
      // flags and reset status cleared on entry
      if (enter_stby) begin
        watchdog_control_status_ff       <= watchdog_control_status_ff & `SMC_WDT_CLR_MASK;
        rst_status_ff <= `SMC_RSTS_RST;
      end
      if (wdt_ovf_evt) begin
        watchdog_control_status_ff[`SMC_WDT_OVF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdcr_ff            <= `SMC_PDCR_RST;
      nmi_edge_select_ff <= 1'b0;
    end else if (wr_pend_ff) begin
      if (addr_is(wr_addr_ff, `SMC_PDCR_ADDR)) begin
        // standby and float bits can only be cleared while watchdog runs
        if (!watchdog_control_status_ff[`SMC_WDT_TME]) begin
          pdcr_ff[`SMC_PDCR_SBY] <= hwdata[`SMC_PDCR_SBY];
          pdcr_ff[`SMC_PDCR_HIZ] <= hwdata[`SMC_PDCR_HIZ];
        end else begin
          pdcr_ff[`SMC_PDCR_SBY] <= pdcr_ff[`SMC_PDCR_SBY] & hwdata[`SMC_PDCR_SBY];
          pdcr_ff[`SMC_PDCR_HIZ] <= pdcr_ff[`SMC_PDCR_HIZ] & hwdata[`SMC_PDCR_HIZ];
        end
      end else if (addr_is(wr_addr_ff, `SMC_CTRL_ADDR)) begin
        nmi_edge_select_ff <= hwdata[`SMC_CTRL_NMI_EDGE_SELECT];
      end
    end
  end

  // Bus: address phase captured here, write data applied in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= acc && hwrite;
      if (acc) begin
        wr_addr_ff <= haddr[`SMC_ADDR_W-1:0];
      end
    end
  end

  always_comb begin
    rd_mux = `SMC_WORD_ZERO;
    if (addr_is(haddr[`SMC_ADDR_W-1:0], `SMC_PDCR_ADDR)) begin
      rd_mux[7:0] = pdcr_ff | `SMC_PDCR_ONES;
    end else if (addr_is(haddr[`SMC_ADDR_W-1:0], `SMC_CTRL_ADDR)) begin
      rd_mux[`SMC_CTRL_NMI_EDGE_SELECT] = nmi_edge_select_ff;
    end else if (addr_is(haddr[`SMC_ADDR_W-1:0], `SMC_WDT_ADDR)) begin
      rd_mux[23:0] = {rst_status_ff, wdt_count_ff, watchdog_control_status_ff};
    end else if (addr_is(haddr[`SMC_ADDR_W-1:0], `SMC_STAT_ADDR)) begin
      rd_mux[3:0] = {nmi_pin, state_ff};
    end
  end

  // Read data is registered at the address phase, so a read that directly follows
  // a write to the same register returns the old value; single transfers avoid it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= `SMC_WORD_ZERO;
    end else if (acc && !hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign hrdata           = hrdata_ff;
  assign hreadyout        = 1'b1;
  assign hresp            = `SMC_HRESP_OKAY;
  assign cpu_halt         = cpu_halt_ff;
  assign clk_en           = clk_en_ff;
  assign init             = init_ff;
  assign wdt_flag_clr     = wdt_flag_clr_ff;
  assign port_float       = port_float_ff;
  assign port_hold        = port_hold_ff;
  assign nmi_exc_req      = nmi_exc_req_ff;
  assign por_req          = por_req_ff;
  assign manual_reset_req = manual_reset_req_ff;
  assign standby_state    = standby_state_ff;

  entry_to_stby_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    enter_stby |=> (state_ff == SMC_ST_STBY) && cpu_halt && standby_state)
    else $error("Standby not entered after sleep with standby bit set.");
  clock_stop_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_ff == SMC_ST_STBY) |-> !clk_en.cpu && !clk_en.periph && !clk_en.wdt)
    else $error("A clock still runs in standby.");
  port_state_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    in_stby |-> (port_float == pdcr_ff[`SMC_PDCR_HIZ]) && (port_hold != port_float))
    else $error("Port state does not follow the float bit.");
  init_pulse_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    enter_stby |=> init.dmac && init.timer && init.serial ##1 !init.dmac)
    else $error("Entry initialise pulse wrong.");
  wdt_entry_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    enter_stby && !wr_pend_ff |=> (watchdog_control_status_ff[7:5] == 3'h0) && (rst_status_ff == 8'h00)
      && (watchdog_control_status_ff[2:0] == $past(watchdog_control_status_ff[2:0])) && (wdt_count_ff == $past(wdt_count_ff)))
    else $error("Watchdog state wrong after standby entry.");
  no_wake_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_ff == SMC_ST_STBY) && reset_pin && !wake_edge |=> state_ff == SMC_ST_STBY)
    else $error("Standby left without NMI edge or reset.");
  nmi_wake_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_ff == SMC_ST_STBY) && reset_pin && wake_edge
      |=> (state_ff == SMC_ST_SETTLE) && clk_en.wdt && !clk_en.cpu && !nmi_exc_req)
    else $error("NMI edge did not start watchdog-only clocking.");
  nmi_exit_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_ff == SMC_ST_SETTLE) && reset_pin && wdt_ovf_evt
      |=> nmi_exc_req && clk_en.cpu && !cpu_halt ##1 !nmi_exc_req)
    else $error("Overflow did not end standby with one NMI request.");

  reset_exit_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    in_stby && !reset_pin
      |=> (por_req == $past(nmi_pin)) && (manual_reset_req != por_req)
      && (state_ff == SMC_ST_RUN))
    else $error("Reset pin exit gives the wrong reset kind.");

  sby_lock_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && addr_is(wr_addr_ff, `SMC_PDCR_ADDR) && watchdog_control_status_ff[`SMC_WDT_TME]
      && !pdcr_ff[`SMC_PDCR_SBY] |=> !pdcr_ff[`SMC_PDCR_SBY])
    else $error("Standby bit set while watchdog runs.");

endmodule : smc_standby

// *** verification/smc_pin_model.sv ***
// Far-side model of the NMI pin, the reset pin and the CPU's sleep strobe.
`timescale 1ns/1ps

module smc_pin_model (
  input  wire logic hclk,
  output logic      nmi_pin,
  output logic      reset_pin,
  output logic      sleep_exec
);
  // Both pins idle high, like a board with pull-ups and no one pressing.
  initial begin
    nmi_pin    = 1'b1;
    reset_pin  = 1'b1;
    sleep_exec = 1'b0;
  end

  task automatic set_nmi(input logic lvl);
    @(posedge hclk);
    nmi_pin <= lvl;
  endtask : set_nmi

  task automatic do_sleep();
    @(posedge hclk);
    sleep_exec <= 1'b1;
    @(posedge hclk);
    sleep_exec <= 1'b0;
  endtask : do_sleep

  task automatic pulse_reset();
    @(posedge hclk);
    reset_pin <= 1'b0;
    @(posedge hclk);
    reset_pin <= 1'b1;
  endtask : pulse_reset
endmodule : smc_pin_model

// *** verification/test_standby_mode_control.sv ***
// Self-checking bench of the standby mode controller.
`timescale 1ns/1ps
`include "smc_defines.svh"

module test_standby_mode_control;
  import smc_pkg::*;

  typedef struct {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } smc_row_s;

  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic               hready;
  logic [31:0]        hrdata;
  logic               hresp;
  logic               sleep_exec;
  logic               nmi_pin;
  logic               reset_pin;
  logic               cpu_halt;
  smc_pkg::smc_clk_s  clk_en;
  smc_pkg::smc_init_s init;
  logic               wdt_flag_clr;
  logic               port_float;
  logic               port_hold;
  logic               nmi_exc_req;
  logic               por_req;
  logic               manual_reset_req;
  logic               standby_state;
  logic [31:0]        rd;
  int                 fail_count;
  int                 num_checks;
  int                 cycles;
  int                 n;

  smc_row_s rows [10] = '{
    '{1'b0, `SMC_PDCR_ADDR, 32'h0, 32'h1F},
    '{1'b0, `SMC_CTRL_ADDR, 32'h0, 32'h0},
    '{1'b0, `SMC_WDT_ADDR, 32'h0, 32'h0},
    '{1'b0, `SMC_STAT_ADDR, 32'h0, 32'h9},
    '{1'b1, 12'h100, 32'hFFFF_FFFF, 32'h0},
    '{1'b1, `SMC_WDT_ADDR, 32'h0000_F020, 32'h0000_F020},
    '{1'b1, `SMC_PDCR_ADDR, 32'hC0, 32'h1F},
    '{1'b1, `SMC_WDT_ADDR, 32'h00AA_F041, 32'h00AA_F041},
    '{1'b1, `SMC_PDCR_ADDR, 32'hC0, 32'hDF},
    '{1'b1, `SMC_PDCR_ADDR, 32'h00, 32'h1F}
  };

  smc_standby dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .sleep_exec(sleep_exec), .nmi_pin(nmi_pin),
    .reset_pin(reset_pin), .cpu_halt(cpu_halt), .clk_en(clk_en), .init(init),
    .wdt_flag_clr(wdt_flag_clr), .port_float(port_float), .port_hold(port_hold),
    .nmi_exc_req(nmi_exc_req), .por_req(por_req), .manual_reset_req(manual_reset_req),
    .standby_state(standby_state)
  );

  smc_pin_model pm (
    .hclk(hclk), .nmi_pin(nmi_pin), .reset_pin(reset_pin), .sleep_exec(sleep_exec)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // The bench's own timeout ends a wait that never sees hready.
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= 32'h0;
  endtask : ahb

  task automatic tick();
    @(posedge hclk);
    #1;
  endtask : tick

  task automatic wait_exc();
    for (n = 0; n < 300 && nmi_exc_req !== 1'b1; n++) tick();
  endtask : wait_exc

  task automatic enter(input logic [31:0] pdcr);
    ahb(1'b1, `SMC_PDCR_ADDR, pdcr);
    pm.do_sleep();
    #1;
  endtask : enter

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) ahb(1'b1, rows[i].a, rows[i].d);
      ahb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].e, "register row");
    end
    $display("test registers done");
    pm.do_sleep();
    repeat (3) tick();
    check({31'h0, standby_state}, 32'h0, "sleep without standby bit");
    enter(32'h80);
    check({31'h0, standby_state}, 32'h1, "standby entered");
    check({30'h0, cpu_halt, hresp}, 32'h2, "cpu halted");
    check({29'h0, clk_en}, 32'h0, "clocks stopped");
    check({28'h0, init, wdt_flag_clr}, 32'hF, "entry init");
    check({30'h0, port_float, port_hold}, 32'h1, "ports held");
    tick();
    check({29'h0, init}, 32'h0, "init one cycle");
    ahb(1'b0, `SMC_WDT_ADDR, 32'h0);
    check(rd, 32'h0000_F001, "watchdog at entry");
    ahb(1'b0, `SMC_PDCR_ADDR, 32'h0);
    check(rd, 32'h9F, "control kept");
    repeat (10) tick();
    check({31'h0, standby_state}, 32'h1, "no wake without edge");
    pm.set_nmi(1'b0);
    for (n = 0; n < 8 && clk_en.wdt !== 1'b1; n++) tick();
    check({28'h0, clk_en, cpu_halt}, 32'h3, "watchdog clock only");
    wait_exc();
    check({31'h0, (n >= 56 && n <= 72)}, 32'h1, "settle length");
    check({27'h0, clk_en, cpu_halt, standby_state}, 32'h1C, "chip clocked");
    tick();
    check({31'h0, nmi_exc_req}, 32'h0, "exception pulse");
    ahb(1'b0, `SMC_WDT_ADDR, 32'h0);
    check(rd & 32'h80, 32'h80, "overflow flag");
    $display("test nmi falling wake done");
    ahb(1'b1, `SMC_WDT_ADDR, 32'h0000_F001);
    enter(32'h80);
    pm.set_nmi(1'b1);
    repeat (20) tick();
    check({31'h0, standby_state}, 32'h1, "rising edge ignored");
    pm.pulse_reset();
    #1;
    check({29'h0, por_req, manual_reset_req, standby_state}, 32'h4, "power-on reset");
    $display("test power-on reset done");
    pm.set_nmi(1'b0);
    ahb(1'b1, `SMC_WDT_ADDR, 32'h0000_F001);
    ahb(1'b1, `SMC_CTRL_ADDR, 32'h1);
    enter(32'hC0);
    check({30'h0, port_float, port_hold}, 32'h2, "ports floated");
    pm.set_nmi(1'b1);
    wait_exc();
    check({31'h0, nmi_exc_req}, 32'h1, "rising edge wake");
    $display("test rising wake done");
    pm.set_nmi(1'b0);
    enter(32'h80);
    pm.pulse_reset();
    #1;
    check({29'h0, por_req, manual_reset_req, standby_state}, 32'h2, "manual reset");
    $display("test manual reset done");
    ahb(1'b1, `SMC_CTRL_ADDR, 32'h0);
    pm.set_nmi(1'b1);
    enter(32'h80);
    pm.set_nmi(1'b0);
    tick();
    check({28'h0, clk_en, standby_state}, 32'h3, "falling edge wakes first");
    pm.pulse_reset();
    #1;
    check({29'h0, por_req, manual_reset_req, standby_state}, 32'h2, "wake then reset");
    $display("test wake before manual reset done");
    @(posedge hclk);
    hresetn <= 1'b0;
    tick();
    check({28'h0, clk_en, cpu_halt}, 32'hE, "state in reset");
    hresetn <= 1'b1;
    ahb(1'b0, `SMC_PDCR_ADDR, 32'h0);
    check(rd, 32'h1F, "control after reset");
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : test_standby_mode_control
